//--- hdl/lbw_map.svh
// Register offsets, reset values, field positions and codes of the local bus wait block
// Assumes inclusion by bare name from the design files
`ifndef LBW_MAP_SVH
`define LBW_MAP_SVH
`define LBW_OFF_MODE        2'h0
`define LBW_OFF_WAIT_LOW    2'h1
`define LBW_OFF_WAIT_HIGH   2'h2
`define LBW_MODE_RESET      8'h20
`define LBW_WAIT_LOW_RESET  8'haa
`define LBW_WAIT_HIGH_RESET 16'haaaa
`define LBW_WAIT_HIGH_FIXED 8'haa
`define LBW_BIT_ROM_FAST    6
`define LBW_BIT_ADDR_WAIT   5
`define LBW_EXT_NONE        3'h0
`define LBW_EXT_256B        3'h1
`define LBW_EXT_4K          3'h2
`define LBW_EXT_16K         3'h3
`define LBW_EXT_64K         3'h4
`define LBW_EXT_256K        3'h5
`define LBW_EXT_1M          3'h7
`define LBW_XSFR_LO         16'hffd0
`define LBW_XSFR_HI         16'hffdf
`define LBW_DATA_TOP        16'hffff
`define LBW_RELOC_PAGE      4'hf
`define LBW_LOW_SPACE_TOP   4'h0
`endif

//--- hdl/lbw_pkg.sv
// Types of the local bus wait block: bus states, wait codes and the state record
// Assumes lbw_map.svh supplies the numeric constants
package lbw_pkg;
  typedef enum logic [2:0] {
    LBW_IDLE  = 3'b000,
    LBW_ALE   = 3'b001,
    LBW_ALEW  = 3'b010,
    LBW_STRB  = 3'b011
  } lbw_state_t;

  typedef enum logic [1:0] {
    LBW_W0   = 2'b00,
    LBW_W1   = 2'b01,
    LBW_W2   = 2'b10,
    LBW_WEXT = 2'b11
  } lbw_wait_t;

  typedef struct packed {
    lbw_state_t st;
    logic [1:0] wcnt;
    lbw_wait_t  wcode;
    logic       intl;
    logic       wr;
    logic [7:0] wdat;
    logic [7:0] mode;
    logic [7:0] wlow;
    logic [7:0] whigh;
    logic [15:0] rdata;
    logic       address_latch_strobe;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] ad;
    logic       ad_oe;
    logic [11:0] ua;
    logic       strb_fn;
    logic       wait_fn;
    logic       done;
    logic [7:0] acc_rdata;
  } lbw_regs_t;
endpackage : lbw_pkg

//--- hdl/lbw_local_bus_wait_control.sv
// Local bus master with address and access wait generation, plus its three control registers
// Assumes a core that issues one access at a time and a register port with 16-bit data
//
// Function
// R01: Bus uses latch, read, write, muxed, upper address
// R02: Bus enable turns port pins into bus functions
// R03: Only upper lines of extension size drive address
// R04: Address wait and access wait are independent
// R05: Mode register holds ROM-cycle and address-wait bits
// R06: Mode register resets to 20H
// R07: Low wait register splits 0-FFFFH into four
// R08: High wait register splits upper space four ways
// R09: Software writes AAH into high byte
// R10: Wait registers reset to AAH and AAAAH
// R11: Software never puts external wait on ROM
// R12: With bus hold, software avoids external wait
// R13: Address wait stretches latch high one clock
// R14: No address wait for RAM, registers, fast ROM
// R15: Slow-cycle internal ROM also gets address wait
// R16: Relocated external registers appear masked on bus
// R17: Two-bit code: 0,1,2 waits or external
// R18: Internal accesses give no strobes, bus floats
// R19: Output address masked to extension size
// R20: Each access wait stretches strobe low one clock
// R21: Wait pin function only when external wait chosen
`timescale 1ns/1ps
`include "lbw_map.svh"
module lbw_local_bus_wait_control #(
  parameter logic [19:0] ROM_TOP  = 20'h1ffff,
  parameter logic [15:0] RAM_BASE = 16'hee00
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [2:0]  ext_size_i,
  input  wire logic        high_relocation_setting_i,
  input  wire logic        acc_req_i,
  input  wire logic        acc_write_i,
  input  wire logic [19:0] acc_addr_i,
  input  wire logic [7:0]  acc_wdata_i,
  output logic             acc_done_o,
  output logic      [7:0]  acc_rdata_o,
  output logic             acc_busy_o,
  output logic             address_latch_strobe_o,
  output logic             read_strobe_n_o,
  output logic             write_strobe_n_o,
  input  wire logic [7:0]  mux_addr_data_lines_i,
  output logic      [7:0]  mux_addr_data_lines_o,
  output logic             mux_addr_data_lines_oe_o,
  output logic      [11:0] upper_address_lines_o,
  output logic      [11:0] upper_address_lines_oe_o,
  output logic             strobe_port_function_o,
  output logic             wait_input_function_o,
  input  wire logic        wait_n_i
);
  logic              rst_meta_q;
  logic              rst_n_q;
  lbw_pkg::lbw_regs_t q;
  lbw_pkg::lbw_regs_t d;
  logic [3:0]        up_lines;
  logic [11:0]       up_oe_d;
  logic [11:0]       up_oe_q;
  logic [19:0]       out_addr;
  logic [19:0]       addr_mask;
  logic [15:0]       page_base;
  logic              in_data;
  logic              in_rom;
  logic              ext_space;
  lbw_pkg::lbw_wait_t wsel;
  logic [7:0]        wfields;
  logic              busy_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Number of upper lines used per extension size
  always_comb begin
    case (ext_size_i)
      `LBW_EXT_NONE:  up_lines = 4'h0;
      `LBW_EXT_256B:  up_lines = 4'h0;
      `LBW_EXT_4K:    up_lines = 4'h4;
      `LBW_EXT_16K:   up_lines = 4'h6;
      `LBW_EXT_64K:   up_lines = 4'h8;
      `LBW_EXT_256K:  up_lines = 4'ha;
      default:        up_lines = 4'hc;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_up
      assign up_oe_d[gi]       = (ext_size_i != `LBW_EXT_NONE) && (4'(gi) < up_lines); // [R03]
      assign addr_mask[gi + 8] = up_oe_d[gi];
    end
  endgenerate
  assign addr_mask[7:0] = 8'hff;
  assign out_addr       = acc_addr_i & addr_mask; // [R19] [R16]

  // Internal areas: data area follows the relocation setting, external registers excepted
  assign page_base = high_relocation_setting_i ? {`LBW_RELOC_PAGE, 12'h000} : 16'h0000;
  assign in_data   = (acc_addr_i[19:16] == page_base[15:12])
                   && (acc_addr_i[15:0] >= RAM_BASE)
                   && !((acc_addr_i[15:0] >= `LBW_XSFR_LO) && (acc_addr_i[15:0] <= `LBW_XSFR_HI));
  assign in_rom    = !in_data && (acc_addr_i <= ROM_TOP);
  assign ext_space = !in_data && !in_rom && (ext_size_i != `LBW_EXT_NONE);

  // Wait field per space: four low spaces, four high spaces [R07] [R08] [R17]
  assign wfields = (acc_addr_i[19:16] == `LBW_LOW_SPACE_TOP) ? q.wlow : q.whigh;
  always_comb begin
    case (acc_addr_i[19:16] == `LBW_LOW_SPACE_TOP ? acc_addr_i[15:14] : acc_addr_i[19:18])
      2'h0:    wsel = lbw_pkg::lbw_wait_t'(wfields[1:0]);
      2'h1:    wsel = lbw_pkg::lbw_wait_t'(wfields[3:2]);
      2'h2:    wsel = lbw_pkg::lbw_wait_t'(wfields[5:4]);
      default: wsel = lbw_pkg::lbw_wait_t'(wfields[7:6]);
    endcase
  end

  always_comb begin
    d           = q;
    d.done      = 1'b0;
    d.strb_fn   = (ext_size_i != `LBW_EXT_NONE); // [R02]
    d.wait_fn   = (q.wlow[1:0] == 2'h3) || (q.wlow[3:2] == 2'h3) || (q.wlow[5:4] == 2'h3)
                || (q.wlow[7:6] == 2'h3) || (q.whigh[1:0] == 2'h3) || (q.whigh[3:2] == 2'h3)
                || (q.whigh[5:4] == 2'h3) || (q.whigh[7:6] == 2'h3); // [R21]
    if (reg_we_i) begin
      case (reg_addr_i)
        `LBW_OFF_MODE:      d.mode  = reg_wdata_i[7:0]; // [R05]
        `LBW_OFF_WAIT_LOW:  d.wlow  = reg_wdata_i[7:0];
        `LBW_OFF_WAIT_HIGH: d.whigh = reg_wdata_i[7:0]; // [R09]
        default: ;
      endcase
    end
    case (reg_addr_i)
      `LBW_OFF_MODE:      d.rdata = {8'h00, q.mode};
      `LBW_OFF_WAIT_LOW:  d.rdata = {8'h00, q.wlow};
      `LBW_OFF_WAIT_HIGH: d.rdata = {`LBW_WAIT_HIGH_FIXED, q.whigh};
      default:            d.rdata = 16'h0000;
    endcase
    if (!reg_re_i) begin
      d.rdata = 16'h0000;
    end
    case (q.st)
      lbw_pkg::LBW_IDLE: begin
        if (acc_req_i) begin
          d.wr    = acc_write_i;
          d.wdat  = acc_wdata_i;
          d.wcode = wsel;
          d.wcnt  = wsel[1:0];
          if (ext_space || (in_rom && !q.mode[`LBW_BIT_ROM_FAST])) begin // [R15]
            d.intl  = !ext_space;
            d.st    = lbw_pkg::LBW_ALE;
            d.address_latch_strobe  = ext_space; // [R01] [R18]
            if (ext_space) begin
              d.ad    = out_addr[7:0];
              d.ad_oe = 1'b1;
              d.ua    = out_addr[19:8];
            end
          end else begin
            d.done      = 1'b1; // [R14] [R18]
            d.acc_rdata = 8'h00;
          end
        end
      end
      lbw_pkg::LBW_ALE: begin
        if (q.mode[`LBW_BIT_ADDR_WAIT]) begin
          d.st = lbw_pkg::LBW_ALEW; // [R13] [R04]
        end else begin
          d.st   = lbw_pkg::LBW_STRB;
          d.address_latch_strobe = 1'b0;
          d.rd_n = q.wr || q.intl;
          d.wr_n = !q.wr || q.intl;
          d.ad   = q.wdat;
          d.ad_oe = q.wr && !q.intl;
        end
      end
      lbw_pkg::LBW_ALEW: begin
        d.st    = lbw_pkg::LBW_STRB;
        d.address_latch_strobe  = 1'b0;
        d.rd_n  = q.wr || q.intl;
        d.wr_n  = !q.wr || q.intl;
        d.ad    = q.wdat;
        d.ad_oe = q.wr && !q.intl;
      end
      lbw_pkg::LBW_STRB: begin
        // Access waits hold the strobe low [R20] [R04]
        if (q.wcode == lbw_pkg::LBW_WEXT ? !wait_n_i : (q.wcnt != 2'h0)) begin
          d.wcnt = q.wcnt - 2'h1;
          if (q.wcode == lbw_pkg::LBW_WEXT) begin
            d.wcnt = q.wcnt;
          end
        end else begin
          d.st        = lbw_pkg::LBW_IDLE;
          d.rd_n      = 1'b1;
          d.wr_n      = 1'b1;
          d.ad_oe     = 1'b0;
          d.done      = 1'b1;
          d.acc_rdata = q.intl ? 8'h00 : mux_addr_data_lines_i;
        end
      end
      default: d.st = lbw_pkg::LBW_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      q           <= '0;
      q.st        <= lbw_pkg::LBW_IDLE;
      q.mode      <= `LBW_MODE_RESET; // [R06]
      q.wlow      <= `LBW_WAIT_LOW_RESET; // [R10]
      q.whigh     <= 8'(`LBW_WAIT_HIGH_RESET);
      q.rd_n      <= 1'b1;
      q.wr_n      <= 1'b1;
      up_oe_q     <= '0;
      busy_q      <= 1'b0;
    end else begin
      q           <= d;
      up_oe_q     <= up_oe_d;
      busy_q      <= (d.st != lbw_pkg::LBW_IDLE);
    end
  end

  assign reg_rdata_o              = q.rdata;
  assign acc_done_o               = q.done;
  assign acc_rdata_o              = q.acc_rdata;
  assign acc_busy_o               = busy_q;
  assign address_latch_strobe_o   = q.address_latch_strobe;
  assign read_strobe_n_o          = q.rd_n;
  assign write_strobe_n_o         = q.wr_n;
  assign mux_addr_data_lines_o    = q.ad;
  assign mux_addr_data_lines_oe_o = q.ad_oe;
  assign upper_address_lines_o    = q.ua;
  assign upper_address_lines_oe_o = up_oe_q;
  assign strobe_port_function_o   = q.strb_fn;
  assign wait_input_function_o    = q.wait_fn;

  sequence s_latch_two;
    address_latch_strobe_o [*2] ##1 !address_latch_strobe_o;
  endsequence
  sequence s_strobe_low(int n);
    !read_strobe_n_o [*1] ##0 1'b1;
  endsequence

  AST_MODE_RESET: assert property (@(posedge core_clk_i) $rose(rst_n_q) |-> // [R06]
    q.mode == `LBW_MODE_RESET) else $error("mode register reset value wrong");
  AST_WAIT_RESET: assert property (@(posedge core_clk_i) $rose(rst_n_q) |-> // [R10]
    q.wlow == `LBW_WAIT_LOW_RESET) else $error("low wait register reset value wrong");
  AST_ADDR_WAIT_ON: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R13]
    $rose(address_latch_strobe_o) && q.mode[`LBW_BIT_ADDR_WAIT] |-> s_latch_two)
    else $error("latch strobe not stretched by one clock");
  AST_ADDR_WAIT_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R13]
    $rose(address_latch_strobe_o) && !q.mode[`LBW_BIT_ADDR_WAIT] |=> !address_latch_strobe_o)
    else $error("latch strobe stretched without address wait");
  AST_TWO_WAITS: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R20]
    $fell(read_strobe_n_o) && q.wcode == lbw_pkg::LBW_W2 |->
    !read_strobe_n_o [*3] ##1 read_strobe_n_o) else $error("two access waits not three clocks");
  AST_ZERO_WAITS: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R20]
    $fell(write_strobe_n_o) && q.wcode == lbw_pkg::LBW_W0 |=> write_strobe_n_o)
    else $error("zero-wait write strobe too long");
  AST_INTERNAL_QUIET: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R18]
    q.st == lbw_pkg::LBW_IDLE && acc_req_i && !ext_space |-> ##1 !address_latch_strobe_o
    ##1 (read_strobe_n_o && write_strobe_n_o)) else $error("strobe on internal access");
  AST_READ_FLOAT: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R18]
    !read_strobe_n_o |-> !mux_addr_data_lines_oe_o) else $error("bus driven during read");
  AST_MASKED: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R19]
    $rose(address_latch_strobe_o) |-> (upper_address_lines_o & ~up_oe_q) == 12'h000)
    else $error("upper address not masked to extension size");
  AST_HIGH_FIXED: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R09]
    reg_re_i && reg_addr_i == `LBW_OFF_WAIT_HIGH |=> reg_rdata_o[15:8] == `LBW_WAIT_HIGH_FIXED)
    else $error("high wait byte not fixed");
  AST_WAIT_PIN: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R21]
    reg_we_i && reg_addr_i == `LBW_OFF_WAIT_LOW && reg_wdata_i[1:0] == 2'h3 |-> ##2
    wait_input_function_o) else $error("wait pin function not taken");
  AST_WAIT_HIGH_RESET: assert property (@(posedge core_clk_i) $rose(rst_n_q) |-> // [R10]
    q.whigh == 8'(`LBW_WAIT_HIGH_RESET)) else $error("high wait register reset value wrong");
  AST_WAIT_PIN_HIGH: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R21]
    reg_we_i && reg_addr_i == `LBW_OFF_WAIT_HIGH && reg_wdata_i[3:2] == 2'h3 |-> ##2
    wait_input_function_o) else $error("wait pin function not taken for high spaces");
  AST_ONE_WAIT: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R20]
    $fell(write_strobe_n_o) && q.wcode == lbw_pkg::LBW_W1 |=> !write_strobe_n_o
    ##1 write_strobe_n_o) else $error("one-wait write strobe not two clocks");
  AST_ONE_STROBE: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R01]
    read_strobe_n_o || write_strobe_n_o) else $error("read and write strobes both active");
  AST_LATCH_APART: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R01]
    !read_strobe_n_o || !write_strobe_n_o |-> !address_latch_strobe_o)
    else $error("latch strobe during data strobe");
  AST_WRITE_DRIVES: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R01]
    !write_strobe_n_o |-> mux_addr_data_lines_oe_o) else $error("bus not driven during write");
  AST_FAST_DONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R14]
    q.st == lbw_pkg::LBW_IDLE && acc_req_i && !ext_space
    && !(in_rom && !q.mode[`LBW_BIT_ROM_FAST]) |=> acc_done_o)
    else $error("internal access not done in one clock");
  AST_PORT_FN: assert property (@(posedge core_clk_i) disable iff (!rst_n_q) // [R02]
    ext_size_i != `LBW_EXT_NONE |=> strobe_port_function_o)
    else $error("port pins not switched to bus functions");
endmodule : lbw_local_bus_wait_control

//--- dv/lbw_ext_mem.sv
// Byte memory on the muxed local bus, with programmable wait stretch
// Assumes an active high latch strobe and active low strobes
`timescale 1ns/1ps
module lbw_ext_mem (
  input  wire logic       clk_i,
  input  wire logic       address_latch_strobe_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] ad_i,
  input  wire logic       ad_oe_i,
  input  wire logic [3:0] stall_i,
  output logic      [7:0] ad_o,
  output logic            wait_n_o
);
  logic [7:0] mem [256];
  logic [7:0] addr_q;
  logic [7:0] last_q = 8'h00;
  logic [3:0] cnt_q  = 4'h0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge clk_i) begin
    if (address_latch_strobe_i && ad_oe_i) addr_q <= ad_i;
    if (!wr_n_i && ad_oe_i) mem[addr_q] <= ad_i;
    cnt_q  <= (rd_n_i && wr_n_i) ? 4'h0 : cnt_q + 4'h1;
    last_q <= ad_o;
  end
  // Released bus toggles so a stale value never passes
  always_comb begin
    if (ad_oe_i) ad_o = ad_i;
    else if (!rd_n_i) ad_o = mem[addr_q];
    else ad_o = ~last_q;
  end
  assign wait_n_o = !((!rd_n_i || !wr_n_i) && cnt_q < stall_i);
endmodule : lbw_ext_mem

//--- dv/local_bus_wait_control_tb_top.sv
// Self-checking bench for the local bus wait block
// Assumes the design with default parameters and one external memory model
`timescale 1ns/1ps
module local_bus_wait_control_tb_top;
  logic clk = 0, rst_n = 0, we = 0, re = 0, req = 0, wr = 0, reloc = 0;
  logic [1:0] ra = 0;
  logic [15:0] wd = 0, rdat, got;
  logic [2:0] sz = 3'h7;
  logic [19:0] aa = 0;
  logic [7:0] dw = 0, ado, adi, rdv, lad;
  logic [11:0] ua, uoe, lua;
  logic done, address_latch_strobe, rdn, wrn, oe, spf, wif, wn, busy;
  logic [3:0] stall = 0;
  int err_count = 0, checks_done = 0, na, nr, nw, lat, nb;
  always #12.5 clk = ~clk;
  lbw_local_bus_wait_control i_dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat), .ext_size_i(sz),
    .high_relocation_setting_i(reloc), .acc_req_i(req), .acc_write_i(wr), .acc_addr_i(aa),
    .acc_wdata_i(dw), .acc_done_o(done), .acc_rdata_o(rdv), .acc_busy_o(busy),
    .address_latch_strobe_o(address_latch_strobe), .read_strobe_n_o(rdn), .write_strobe_n_o(wrn),
    .mux_addr_data_lines_i(adi), .mux_addr_data_lines_o(ado), .mux_addr_data_lines_oe_o(oe),
    .upper_address_lines_o(ua), .upper_address_lines_oe_o(uoe),
    .strobe_port_function_o(spf), .wait_input_function_o(wif), .wait_n_i(wn));
  lbw_ext_mem i_mem (.clk_i(clk), .address_latch_strobe_i(address_latch_strobe), .rd_n_i(rdn), .wr_n_i(wrn), .ad_i(ado),
    .ad_oe_i(oe), .stall_i(stall), .ad_o(adi), .wait_n_o(wn));
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1; ra <= a; wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] a);
    @(posedge clk);
    re <= 1'b1; ra <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 got = rdat;
  endtask : reg_rd
  task automatic acc(input logic w, input logic [19:0] a, input logic [7:0] d);
    na = 0; nr = 0; nw = 0; lat = 0; nb = 0;
    @(posedge clk);
    req <= 1'b1; wr <= w; aa <= a; dw <= d;
    @(posedge clk);
    req <= 1'b0;
    for (int i = 1; i < 60 && lat == 0; i++) begin
      #1;
      if (address_latch_strobe === 1'b1) begin
        if (na == 0) begin lad = ado; lua = ua; end
        na++;
      end
      if (rdn === 1'b0) nr++;
      if (wrn === 1'b0) nw++;
      if (busy === 1'b1) nb++;
      if (done === 1'b1) lat = i; else @(posedge clk);
    end
    if (lat == 0) begin
      err_count++;
      $display("mismatch at %0t: access timed out", $time);
    end
    @(posedge clk);
  endtask : acc
  task automatic t_regs;
    reg_rd(2'h0); chk(got[7:0] === 8'h20, "mode reset");
    reg_rd(2'h1); chk(got[7:0] === 8'haa, "low wait reset");
    reg_rd(2'h2); chk(got === 16'haaaa, "high wait reset");
    reg_rd(2'h3); chk(got === 16'h0000, "unmapped read");
    chk(wif === 1'b0 && spf === 1'b1, "pin functions after reset");
    reg_wr(2'h2, 16'h5566);
    reg_rd(2'h2); chk(got === 16'haa66, "high byte fixed");
    reg_wr(2'h2, 16'haaaa);
  endtask : t_regs
  task automatic t_waits;
    for (int aw = 0; aw < 2; aw++) for (int n = 0; n < 3; n++) begin
      reg_wr(2'h0, aw ? 16'h0020 : 16'h0000);
      reg_wr(2'h2, {8'haa, 4'ha, 2'(n), 2'h2});
      acc(1'b1, 20'h40021 + 20'(n), 8'hc0 + 8'(n));
      chk(na == 1 + aw && nw == 1 + n && nr == 0, "write phases");
      chk(lat == n + 3 + aw && lad === 8'h21 + 8'(n), "write timing");
      chk(nb == lat - 1, "busy span");
      acc(1'b0, 20'h40021 + 20'(n), 8'h00);
      chk(nr == 1 + n && rdv === 8'hc0 + 8'(n), "read back");
    end
    reg_wr(2'h2, 16'haaaa);
  endtask : t_waits
  task automatic t_internal;
    reg_wr(2'h0, 16'h0020);
    acc(1'b0, 20'h00100, 8'h00);
    chk(na == 0 && nr == 0 && lat == 6 && ua === lua, "slow rom");
    reg_wr(2'h0, 16'h0060);
    acc(1'b0, 20'h00100, 8'h00); chk(na == 0 && lat == 1, "fast rom");
    acc(1'b1, 20'h0ee10, 8'h33); chk(na + nw == 0 && lat == 1, "internal ram");
    reg_wr(2'h0, 16'h0020);
  endtask : t_internal
  task automatic t_size;
    logic [11:0] m [8] = '{12'h000, 12'h000, 12'h00f, 12'h03f, 12'h0ff, 12'h3ff, 12'hfff,
                           12'hfff};
    for (int s = 0; s < 8; s++) begin
      sz <= 3'(s);
      repeat (3) @(posedge clk);
      chk(uoe === m[s] && spf === (s != 0), "address lines by size");
    end
    sz <= 3'h1;
    acc(1'b0, 20'h54321, 8'h00); chk(lad === 8'h21 && na == 2, "masked address");
    reloc <= 1'b1;
    for (int s = 4; s < 8; s += (s == 5) ? 2 : 1) begin
      sz <= 3'(s);
      acc(1'b0, 20'hfffd0, 8'h00);
      chk(lad === 8'hd0 && lua === m[s], "relocated register");
    end
    reloc <= 1'b0;
  endtask : t_size
  task automatic t_extwait;
    reg_wr(2'h2, 16'haaae);
    repeat (2) @(posedge clk);
    chk(wif === 1'b1, "wait pin taken");
    stall <= 4'h3;
    acc(1'b0, 20'h40021, 8'h00); chk(nr == 4, "external wait stretch");
    stall <= 4'h0;
    reg_wr(2'h2, 16'haaaa);
    repeat (2) @(posedge clk);
    chk(wif === 1'b0, "wait pin released");
  endtask : t_extwait
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_waits();
    t_internal();
    t_size();
    t_extwait();
    print_verdict();
  end
  initial begin
    #(25 * 20000);
    err_count++;
    print_verdict();
  end
endmodule : local_bus_wait_control_tb_top
